// >>> hw/gese_defines.vh
`ifndef GESE_DEFINES_VH
`define GESE_DEFINES_VH

// Register indices; byte address is four times the index
`define GESE_IDX_STATUS 10'h0A8
`define GESE_IDX_ENABLE 10'h0AA
`define GESE_IDX_CARD_CTRL 10'h0B0
`define GESE_IDX_POWER 10'h0B1
`define GESE_IDX_TERM_CFG 10'h0B2
`define GESE_IDX_GP_DATA 10'h0B3

// Event bit positions, shared by status and enable
`define GESE_BIT_VIDEO 15
`define GESE_BIT_POWER 11
`define GESE_BIT_PROG12 8
`define GESE_GP_LSB 0
`define GESE_GP_MSB 4

// Implemented bits of status and enable; the rest read zero
`define GESE_EVENT_MASK 16'h891F
`define GESE_STATUS_RESET 16'h0000
`define GESE_ENABLE_RESET 16'h0000

// Card control: video port enable bit
`define GESE_BIT_VIDEO_ON 6
`define GESE_CARD_CTRL_RESET 1'h0

// Power control: supply select and programming voltage select
`define GESE_VCC_LSB 0
`define GESE_VCC_MSB 1
`define GESE_VPP_LSB 4
`define GESE_VPP_MSB 5
`define GESE_VPP_12V 2'h2
`define GESE_VCC_RESET 2'h0
`define GESE_VPP_RESET 2'h0

// Terminal configuration: input select and event pin select
`define GESE_CFG_GPI_LSB 0
`define GESE_CFG_GPI_MSB 4
`define GESE_CFG_PIN_LSB 8
`define GESE_CFG_PIN_MSB 10
`define GESE_CFG_GPI_RESET 5'h00
`define GESE_CFG_PIN_RESET 3'h7

// Input edge detector warm-up, in clock edges
`define GESE_PRIME_CYCLES 2'h3

`endif

// >>> hw/gese_sync.v
`include "gese_defines.vh"

// Two-flop synchroniser with one-shot change detection per input
module gese_sync #(
	parameter WIDTH = 5
) (
	input wire clock,
	input wire arst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] change
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	reg [WIDTH-1:0] last_ff;
	reg [1:0] prime_ff;
	wire primed;

	assign primed = (prime_ff == `GESE_PRIME_CYCLES);

	// Capture chain; the first stage feeds only the second
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
			last_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	// Warm-up so a high input at reset release is not seen as an edge
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prime_ff <= 2'h0;
		end else if (!primed) begin
			prime_ff <= prime_ff + 2'h1;
		end
	end

	assign level = sync_ff;
	assign change = primed ? (sync_ff ^ last_ff) : {WIDTH{1'b0}};
endmodule // gese_sync

// >>> hw/gese_top.v
// Overview of operation
// - Writing one to a status bit clears it and its event contribution.
// - Status bit 15 sets when the video port enable bit changes.
// - Status bit 11 sets when software changes supply or programming voltage.
// - Status bit 8 sets when programming voltage moves to or from 12 V.
// - Status bits 4..0 set on either edge of their input terminal.
// - Input changes are recorded regardless of the enable bits.
// - Reserved bits of status and enable read zero, ignore writes.
// - Enable bit 15 lets a video change assert the event output.
// - Enable bit 11 lets a power change assert the event output.
// - Enable bit 8 lets a 12 V request change assert the event output.
// - Enable bits 4..0 assert the output only for terminals configured as inputs.
// - Event output is OR of enabled set status bits, held until cleared.
// - Event drives a terminal only when one is configured for it.
//
// Register access over AHB-Lite was chosen for this implementation.
`include "gese_defines.vh"

module gese_top #(
	parameter GP_COUNT = 5,
	parameter PIN_COUNT = 7
) (
	input wire clock,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [GP_COUNT-1:0] gp_input,
	output wire general_event_out_n,
	output wire irq,
	output wire [PIN_COUNT-1:0] event_pin_out,
	output wire [PIN_COUNT-1:0] event_pin_oe,
	output wire video_port_on,
	output wire [1:0] vcc_sel,
	output wire [1:0] vpp_sel
);
	// Bus states, one-hot
	localparam ST_IDLE = 3'b001;
	localparam ST_BUSY = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [9:0] idx_ff;
	reg write_ff;
	reg [31:0] hrdata_ff;
	reg [31:0] nxt_hrdata;
	// Sticky status and its next value
	reg [15:0] status_ff;
	reg [15:0] nxt_status;
	// Software-written registers, each with its next value
	reg [15:0] enable_ff;
	reg [15:0] nxt_enable;
	reg video_on_ff;
	reg nxt_video_on;
	reg [1:0] vcc_ff;
	reg [1:0] nxt_vcc;
	reg [1:0] vpp_ff;
	reg [1:0] nxt_vpp;
	reg [GP_COUNT-1:0] gpi_cfg_ff;
	reg [GP_COUNT-1:0] nxt_gpi_cfg;
	reg [2:0] pin_sel_ff;
	reg [2:0] nxt_pin_sel;
	reg event_ff;
	reg irq_ff;
	reg [PIN_COUNT-1:0] pin_oe_ff;
	reg [PIN_COUNT-1:0] nxt_pin_oe;
	reg [15:0] set_vec;
	reg [15:0] eff_enable;
	integer i;
	integer j;
	integer k;

	wire take;
	wire do_access;
	wire do_write;
	wire [15:0] wdata;
	wire [GP_COUNT-1:0] gp_level;
	wire [GP_COUNT-1:0] gp_change;
	wire video_chg;
	wire power_chg;
	wire prog12_chg;
	wire [1:0] new_vcc;
	wire [1:0] new_vpp;
	// Event terms ahead of the output flops
	wire event_now;
	wire irq_now;

	// Index match on the word address of the captured transfer
	function hit;
		input [9:0] idx;
		input [9:0] want;
		begin
			hit = (idx == want);
		end
	endfunction

	// True when a programming voltage code requests 12 V
	function is_12v;
		input [1:0] code;
		begin
			is_12v = (code == `GESE_VPP_12V);
		end
	endfunction

	// Synchronised terminal inputs and their edges
	gese_sync #(
		.WIDTH(GP_COUNT)
	) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.async_in(gp_input),
		.level(gp_level),
		.change(gp_change)
	);

	// Address phase is taken only while the bus is ready
	assign take = hsel && htrans[1] && hready;
	assign do_access = (state_ff == ST_BUSY);
	assign do_write = do_access && write_ff;
	assign wdata = hwdata[15:0];

	// One wait state lets a write settle before read data is sampled
	assign hreadyout = (state_ff != ST_BUSY);
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	// Bus sequencer
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				nxt_state = ST_DONE;
			end
			ST_DONE: begin
				if (take) begin
					nxt_state = ST_BUSY;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer and address capture
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			idx_ff <= 10'h000;
			write_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (take) begin
				idx_ff <= haddr[11:2];
				write_ff <= hwrite;
			end
		end
	end

	// Proposed values of the power control fields
	assign new_vcc = wdata[`GESE_VCC_MSB:`GESE_VCC_LSB];
	assign new_vpp = wdata[`GESE_VPP_MSB:`GESE_VPP_LSB];

	assign video_chg = do_write && hit(idx_ff, `GESE_IDX_CARD_CTRL) && (wdata[`GESE_BIT_VIDEO_ON] != video_on_ff);
	assign power_chg = do_write && hit(idx_ff, `GESE_IDX_POWER) && ((new_vcc != vcc_ff) || (new_vpp != vpp_ff));
	assign prog12_chg = do_write && hit(idx_ff, `GESE_IDX_POWER) && (is_12v(new_vpp) != is_12v(vpp_ff));

	// Gather this cycle's events into status layout
	always @* begin
		set_vec = 16'h0000;
		set_vec[`GESE_BIT_VIDEO] = video_chg;
		set_vec[`GESE_BIT_POWER] = power_chg;
		set_vec[`GESE_BIT_PROG12] = prog12_chg;
		for (i = 0; i < GP_COUNT; i = i + 1) begin
			set_vec[`GESE_GP_LSB + i] = gp_change[i];
		end
	end

	// Sticky status; a set in the clearing cycle wins
	always @* begin
		nxt_status = status_ff;
		if (do_write && hit(idx_ff, `GESE_IDX_STATUS)) begin
			nxt_status = status_ff & ~wdata;
		end
		nxt_status = (nxt_status | set_vec) & `GESE_EVENT_MASK;
	end

	// Status register
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_ff <= `GESE_STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Next values of the software-written registers
	// The outputs are built from these, so a write to enable or routing shows at the
	// same edge as a status write; the event output then only drops at a write edge
	always @* begin
		nxt_enable = enable_ff;
		nxt_video_on = video_on_ff;
		nxt_vcc = vcc_ff;
		nxt_vpp = vpp_ff;
		nxt_gpi_cfg = gpi_cfg_ff;
		nxt_pin_sel = pin_sel_ff;
		if (do_write) begin
			if (hit(idx_ff, `GESE_IDX_ENABLE)) begin
				nxt_enable = wdata & `GESE_EVENT_MASK;
			end
			if (hit(idx_ff, `GESE_IDX_CARD_CTRL)) begin
				nxt_video_on = wdata[`GESE_BIT_VIDEO_ON];
			end
			if (hit(idx_ff, `GESE_IDX_POWER)) begin
				nxt_vcc = new_vcc;
				nxt_vpp = new_vpp;
			end
			if (hit(idx_ff, `GESE_IDX_TERM_CFG)) begin
				nxt_gpi_cfg = wdata[`GESE_CFG_GPI_MSB:`GESE_CFG_GPI_LSB];
				nxt_pin_sel = wdata[`GESE_CFG_PIN_MSB:`GESE_CFG_PIN_LSB];
			end
		end
	end

	// Software-written control registers
	// Plain copies of the next values; all decoding lives in the block above
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable_ff <= `GESE_ENABLE_RESET;
			video_on_ff <= `GESE_CARD_CTRL_RESET;
			vcc_ff <= `GESE_VCC_RESET;
			vpp_ff <= `GESE_VPP_RESET;
			gpi_cfg_ff <= `GESE_CFG_GPI_RESET;
			pin_sel_ff <= `GESE_CFG_PIN_RESET;
		end else begin
			enable_ff <= nxt_enable;
			video_on_ff <= nxt_video_on;
			vcc_ff <= nxt_vcc;
			vpp_ff <= nxt_vpp;
			gpi_cfg_ff <= nxt_gpi_cfg;
			pin_sel_ff <= nxt_pin_sel;
		end
	end

	// Read mux; unmapped words read zero
	always @* begin
		nxt_hrdata = 32'h00000000;
		if (hit(idx_ff, `GESE_IDX_STATUS)) begin
			nxt_hrdata[15:0] = status_ff;
		end else if (hit(idx_ff, `GESE_IDX_ENABLE)) begin
			nxt_hrdata[15:0] = enable_ff;
		end else if (hit(idx_ff, `GESE_IDX_CARD_CTRL)) begin
			nxt_hrdata[`GESE_BIT_VIDEO_ON] = video_on_ff;
		end else if (hit(idx_ff, `GESE_IDX_POWER)) begin
			nxt_hrdata[`GESE_VCC_MSB:`GESE_VCC_LSB] = vcc_ff;
			nxt_hrdata[`GESE_VPP_MSB:`GESE_VPP_LSB] = vpp_ff;
		end else if (hit(idx_ff, `GESE_IDX_TERM_CFG)) begin
			nxt_hrdata[`GESE_CFG_GPI_MSB:`GESE_CFG_GPI_LSB] = gpi_cfg_ff;
			nxt_hrdata[`GESE_CFG_PIN_MSB:`GESE_CFG_PIN_LSB] = pin_sel_ff;
		end else if (hit(idx_ff, `GESE_IDX_GP_DATA)) begin
			nxt_hrdata[GP_COUNT-1:0] = gp_level;
		end
	end

	// Read data is captured at the wait-state edge, after any write there
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hrdata_ff <= 32'h00000000;
		end else if (do_access && !write_ff) begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	// Input enables count only for terminals configured as inputs
	// Built from next values so a configuration write gates the output at once
	always @* begin
		eff_enable = nxt_enable;
		for (j = 0; j < GP_COUNT; j = j + 1) begin
			eff_enable[`GESE_GP_LSB + j] = nxt_enable[`GESE_GP_LSB + j] & nxt_gpi_cfg[j];
		end
	end

	// True when any flag is both set and enabled
	function any_set;
		input [15:0] flags;
		input [15:0] mask;
		begin
			any_set = |(flags & mask);
		end
	endfunction

	// Event terms from next status and next enables, shared by the flops and the pin drive
	assign event_now = any_set(nxt_status, eff_enable);
	// The interrupt skips the input-config gating, so it also reports unrouted terminals
	assign irq_now = any_set(nxt_status, nxt_enable);

	// Event pin drive: open drain, low only on the selected terminal
	// A select of seven routes the event nowhere; the internal level still moves
	always @* begin
		nxt_pin_oe = {PIN_COUNT{1'b0}};
		for (k = 0; k < PIN_COUNT; k = k + 1) begin
			if (nxt_pin_sel == k[2:0]) begin
				nxt_pin_oe[k] = event_now;
			end
		end
	end

	// Event outputs registered from next values so they track the status bit exactly
	// A drop therefore only happens at the edge that performs a software write
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			event_ff <= 1'b0;
			irq_ff <= 1'b0;
			pin_oe_ff <= {PIN_COUNT{1'b0}};
		end else begin
			event_ff <= event_now;
			irq_ff <= irq_now;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	// Outputs straight from flops; pin data stays low, the enable alone drives the terminal
	assign general_event_out_n = ~event_ff;
	assign irq = irq_ff;
	assign event_pin_out = {PIN_COUNT{1'b0}};
	assign event_pin_oe = pin_oe_ff;
	assign video_port_on = video_on_ff;
	assign vcc_sel = vcc_ff;
	assign vpp_sel = vpp_ff;
endmodule // gese_top

// >>> tb/gese_asserts.sv
// Port-level checks of the event block
module gese_asserts #(
	parameter PIN_COUNT = 7
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq,
	input wire logic general_event_out_n,
	input wire logic [PIN_COUNT-1:0] event_pin_out,
	input wire logic [PIN_COUNT-1:0] event_pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	// Address phase taken, then one wait cycle
	sequence s_taken;
		hsel && htrans[1] && hready;
	endsequence
	sequence s_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	bus_answer_a: assert property (s_taken |=> s_answer) else $error("bus answer not in two cycles");
	okay_resp_a: assert property (hresp == 1'h0) else $error("response not okay");
	pin_low_a: assert property (event_pin_out == '0) else $error("pin data not low");
	pin_single_a: assert property ($onehot0(event_pin_oe)) else $error("several pins driven");
	pin_needs_event_a: assert property (|event_pin_oe |-> !general_event_out_n) else $error("pin without event");
	out_gated_a: assert property (!general_event_out_n |-> irq) else $error("event without status");
	// Outputs drop only at a write edge, so they hold until cleared
	irq_held_a: assert property ($fell(irq) |-> !$past(hreadyout)) else $error("irq dropped alone");
	out_held_a: assert property ($rose(general_event_out_n) |-> !$past(hreadyout)) else $error("event dropped");
endmodule // gese_asserts

// >>> tb/gese_term_model.sv
// Terminal side: levels move off the clock grid, as real pins do
module gese_term_model (
	input wire logic [4:0] want,
	output logic [4:0] gp_input
);
	timeunit 1ns;
	timeprecision 1ns;
	initial gp_input = 5'h00;
	// Fixed skew keeps each change away from the sampling edge
	always @(want) gp_input <= #37 want;
endmodule // gese_term_model

// >>> tb/testbench.sv
`include "gese_defines.vh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [4:0] want = 5'h00;
	wire [31:0] hrdata;
	wire hreadyout, hresp, irq, general_event_out_n, video_port_on;
	wire [4:0] gp_input;
	wire [6:0] event_pin_out, event_pin_oe;
	wire [1:0] vcc_sel, vpp_sel;
	int err_total = 0, checked = 0, cyc = 0;
	logic [31:0] rnd = 32'hF86C, r;
	logic [15:0] st = 16'h0, en = 16'h0;
	logic [5:0] pw = 6'h0;
	logic vid = 1'h0;
	logic [4:0] gpi = 5'h0;
	logic [2:0] pin = 3'h7;
	logic [41:0] tab [0:15];

	always #50 clock = ~clock;

	gese_top i_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .gp_input(gp_input), .general_event_out_n(general_event_out_n),
		.irq(irq), .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe),
		.video_port_on(video_port_on), .vcc_sel(vcc_sel), .vpp_sel(vpp_sel));
	gese_term_model i_term (.want(want), .gp_input(gp_input));

	task conclude;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			conclude;
		end
	end

	task chk(input [31:0] seen, input [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// One single transfer; no cycle count assumed
	task xfer(input logic w, input [9:0] i, input [31:0] d);
		@(posedge clock);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, i, 2'h0};
		@(posedge clock);
		while (hreadyout !== 1'h1) @(posedge clock);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'h1) @(posedge clock);
		r = hrdata;
	endtask

	task look;
		logic [15:0] ev;
		ev = st & en & {11'h7FF, gpi};
		chk(irq, |(st & en));
		chk(general_event_out_n, ~|ev);
		chk(event_pin_oe, (|ev && pin != 3'h7) ? 7'h01 << pin : 7'h00);
		chk({video_port_on, vcc_sel, vpp_sel}, {vid, pw[1:0], pw[5:4]});
		xfer(1'h0, `GESE_IDX_STATUS, 32'h0);
		chk(r, st);
		xfer(1'h0, `GESE_IDX_ENABLE, 32'h0);
		chk(r, en);
	endtask

	// Write, then update the reference and compare
	task put(input [9:0] i, input [31:0] d);
		xfer(1'h1, i, d);
		case (i)
			`GESE_IDX_STATUS: st = st & ~d[15:0];
			`GESE_IDX_ENABLE: en = d[15:0] & `GESE_EVENT_MASK;
			`GESE_IDX_CARD_CTRL: begin
				if (d[6] != vid) st = st | 16'h8000;
				vid = d[6];
			end
			`GESE_IDX_POWER: begin
				if ((d[5:0] & 6'h33) != pw) st = st | 16'h0800;
				if ((d[5:4] == 2'h2) != (pw[5:4] == 2'h2)) st = st | 16'h0100;
				pw = d[5:0] & 6'h33;
			end
			`GESE_IDX_TERM_CFG: begin
				gpi = d[4:0];
				pin = d[10:8];
			end
			default: ;
		endcase
		look;
	endtask

	initial begin
		tab = '{{`GESE_IDX_ENABLE, 32'hFFFFFFFF}, {`GESE_IDX_ENABLE, 32'h0},
			{`GESE_IDX_CARD_CTRL, 32'h40}, {`GESE_IDX_CARD_CTRL, 32'h40},
			{`GESE_IDX_ENABLE, 32'h8000}, {`GESE_IDX_TERM_CFG, 32'h300},
			{`GESE_IDX_STATUS, 32'h7FFF}, {`GESE_IDX_STATUS, 32'h8000},
			{`GESE_IDX_ENABLE, 32'h0900}, {`GESE_IDX_POWER, 32'h01},
			{`GESE_IDX_POWER, 32'h21}, {`GESE_IDX_POWER, 32'h11},
			{`GESE_IDX_STATUS, 32'h0900}, {`GESE_IDX_POWER, 32'h31},
			{`GESE_IDX_POWER, 32'h31}, {10'h3F0, 32'hFFFF}};
		repeat (12) @(posedge clock);
		arst_n <= 1'h1;
		look;
		$display("test reset done");
		foreach (tab[k]) put(tab[k][41:32], tab[k][31:0]);
		xfer(1'h0, 10'h3F0, 32'h0);
		chk(r, 32'h0);
		$display("test register events done");
		// Random terminal edges under random config and enables
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			put(`GESE_IDX_TERM_CFG, rnd & 32'h071F);
			put(`GESE_IDX_ENABLE, {16'h0, rnd[31:16]});
			@(posedge clock);
			want <= rnd[15:11];
			st = st | {11'h0, want ^ rnd[15:11]};
			repeat (10) @(posedge clock);
			look;
			xfer(1'h0, `GESE_IDX_GP_DATA, 32'h0);
			chk(r, {27'h0, rnd[15:11]});
			xfer(1'h0, `GESE_IDX_TERM_CFG, 32'h0);
			chk(r, rnd & 32'h071F);
			put(`GESE_IDX_STATUS, {16'h0, rnd[15:0]});
		end
		$display("test terminal events done");
		conclude;
	end
endmodule // testbench

bind gese_top gese_asserts #(.PIN_COUNT(PIN_COUNT)) i_chk (.clock(clock), .arst_n(arst_n), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.general_event_out_n(general_event_out_n), .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe));
